// ===== design/opv_mode_decode.sv
// decodes the select pins and voltage levels into one operating mode
`timescale 1ns/1ps
`default_nettype none

module opv_mode_decode (
	input  wire logic              reset_pin_high,   // reset pin held at programming level
	input  wire logic              fetch_strobe_n,   // program_fetch_strobe_n pin
	input  wire logic              strobe,           // latch_or_program_strobe pin level
	input  wire logic              vpp_present,      // programming voltage sensed on pin
	input  wire logic              ea_logic_high,    // pin at valid logic high
	input  wire logic              sel6,             // mode_sel_six
	input  wire logic              sel7_en,          // mode_sel_seven_enable
	input  wire logic              sel33,            // mode_sel_three_three
	input  wire logic              sel36,            // mode_sel_three_six
	input  wire logic              sel37,            // mode_sel_three_seven
	output opv_pkg::opv_mode_t     mode              // decoded mode
);
	import opv_pkg::*;

	logic [4:0] sel;

	always_comb begin
		sel  = {sel6, sel7_en, sel33, sel36, sel37};
		mode = OPV_MODE_IDLE;
		if (reset_pin_high && !fetch_strobe_n) begin
			if (vpp_present) begin
				// write modes need the programming voltage
				if (sel == 5'b01111) begin
					mode = OPV_MODE_PROG_CODE;
				end else if (sel == 5'b01101) begin
					mode = OPV_MODE_PROG_ENC;
				end else if (sel == 5'b11111) begin
					mode = OPV_MODE_PROG_LOCK1;
				end else if (sel == 5'b11100) begin
					mode = OPV_MODE_PROG_LOCK2;
				end else if (sel == 5'b10110) begin
					mode = OPV_MODE_PROG_LOCK3;
				end
			end else if (ea_logic_high && strobe) begin
				// reads only with the pin back at logic high
				if (sel == 5'b00011) begin
					mode = OPV_MODE_VERIFY;
				end else if (sel == 5'b00000) begin
					mode = OPV_MODE_SIGNATURE;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ===== design/opv_prog_port.sv
// program and verify port of the on-chip one-time-programmable code array
// Summary of operation
// - address from low port and five bits
// - write data taken from port zero
// - strobe pulse commits byte to location
// - lock bits have no direct readback
// - verify returns code XNOR encryption byte
// - signature bytes at 30H, 31H, 60H
// - lock levels block program, verify, external run
`include "opv_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module opv_prog_port #(
	parameter int            ADDR_W    = 13,     // implemented code address bits
	parameter logic [7:0]    SIG_BYTE0 = 8'hA5,  // arbitrary identification value
	parameter logic [7:0]    SIG_BYTE1 = 8'h5A,  // arbitrary identification value
	parameter logic [7:0]    SIG_BYTE2 = 8'h3C   // arbitrary identification value
) (
	input  wire logic              clk,                // device oscillator
	input  wire logic              rst_n,              // async reset, active low
	input  wire logic              reset_pin_high,     // reset pin at programming level
	input  wire logic              program_fetch_strobe_n, // fetch strobe pin
	input  wire logic              latch_or_program_strobe, // low pulse writes
	input  wire logic              vpp_present,        // programming voltage sensed
	input  wire logic              ea_logic_high,      // access pin at logic high
	input  wire logic              mode_sel_six,       // select pin
	input  wire logic              mode_sel_seven_enable, // select and read enable pin
	input  wire logic              mode_sel_three_three, // select pin
	input  wire logic              mode_sel_three_six, // select pin
	input  wire logic              mode_sel_three_seven, // select pin
	input  wire logic [7:0]        addr_lo,            // low address port
	input  wire logic [4:0]        addr_hi,            // upper address bits
	input  wire opv_pkg::opv_byte_t port0_in,          // port zero pin level
	output opv_pkg::opv_byte_t     port0_out,          // port zero drive value
	output logic                   port0_oe,           // port zero driven when high
	output logic                   lock_level_one,     // first lock bit programmed
	output logic                   lock_level_two,     // first and second lock bits programmed
	output logic                   lock_level_three,   // all three lock bits programmed
	output logic                   code_table_read_block, // external table reads blocked
	output logic                   ea_effective,       // access level seen by core
	output logic                   ext_exec_disable    // external execution disabled
);
	import opv_pkg::*;

	// refuse address widths that cannot hold the encryption index
	if (ADDR_W < `OPV_ENC_IDX_W || ADDR_W > `OPV_PIN_ADDR_W) begin : g_bad_addr_w
		$error("ADDR_W out of range");
	end

	// =================================================================
	// reset release
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// =================================================================
	// mode decode
	opv_mode_t mode;

	opv_mode_decode u_decode (
		.reset_pin_high (reset_pin_high),
		.fetch_strobe_n (program_fetch_strobe_n),
		.strobe         (latch_or_program_strobe),
		.vpp_present    (vpp_present),
		.ea_logic_high  (ea_logic_high),
		.sel6           (mode_sel_six),
		.sel7_en        (mode_sel_seven_enable),
		.sel33          (mode_sel_three_three),
		.sel36          (mode_sel_three_six),
		.sel37          (mode_sel_three_seven),
		.mode           (mode)
	);

	// =================================================================
	// nonvolatile arrays; contents survive reset, erased state is all ones
	opv_byte_t code_mem [2**ADDR_W]      = '{default: `OPV_ERASED_BYTE};
	opv_byte_t enc_mem  [`OPV_ENC_DEPTH] = '{default: `OPV_ERASED_BYTE};
	logic      lock1_q                   = 1'b0;
	logic      lock2_q                   = 1'b0;
	logic      lock3_q                   = 1'b0;

	logic [12:0]                 pin_addr;
	logic [ADDR_W-1:0]           code_addr;
	logic [`OPV_ENC_IDX_W-1:0]   enc_addr;
	assign pin_addr  = {addr_hi, addr_lo};
	assign code_addr = pin_addr[ADDR_W-1:0];
	assign enc_addr  = pin_addr[`OPV_ENC_IDX_W-1:0];

	// =================================================================
	// strobe tracking: a write commits when the low pulse ends
	logic      strobe_q;
	logic      strobe_d;
	opv_mode_t pulse_mode_q;
	opv_mode_t pulse_mode_d;
	logic      write_en;
	logic      code_we;
	logic      enc_we;

	always_comb begin
		strobe_d     = latch_or_program_strobe;
		pulse_mode_d = pulse_mode_q;
		if (strobe_q && !latch_or_program_strobe) begin
			pulse_mode_d = mode;
		end
	end

	// commit on rising end of pulse, mode held stable
	assign write_en = !strobe_q && latch_or_program_strobe
	                  && pulse_mode_q == mode && mode != OPV_MODE_IDLE
	                  && mode != OPV_MODE_VERIFY && mode != OPV_MODE_SIGNATURE;

	// first lock refuses array writes
	// higher lock levels must still be addable once the first is set
	assign code_we = write_en && !lock1_q && mode == OPV_MODE_PROG_CODE;
	assign enc_we  = write_en && !lock1_q && mode == OPV_MODE_PROG_ENC;

	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			strobe_q     <= 1'b1;
			pulse_mode_q <= OPV_MODE_IDLE;
		end else begin
			strobe_q     <= strobe_d;
			pulse_mode_q <= pulse_mode_d;
		end
	end

	// programming can only clear bits, so repeated pulses are harmless
	always_ff @(posedge clk) begin
		if (code_we) begin
			code_mem[code_addr] <= code_mem[code_addr] & port0_in;
		end
		if (enc_we) begin
			enc_mem[enc_addr] <= enc_mem[enc_addr] & port0_in;
		end
		if (write_en && mode == OPV_MODE_PROG_LOCK1) begin
			lock1_q <= 1'b1;
		end
		if (write_en && mode == OPV_MODE_PROG_LOCK2) begin
			lock2_q <= 1'b1;
		end
		if (write_en && mode == OPV_MODE_PROG_LOCK3) begin
			lock3_q <= 1'b1;
		end
	end

	// =================================================================
	// read path
	function automatic opv_byte_t sig_lookup(input logic [12:0] a);
		opv_byte_t r;
		r = `OPV_IDLE_BYTE;
		if (a == `OPV_SIG_LOC0) begin
			r = SIG_BYTE0;
		end else if (a == `OPV_SIG_LOC1) begin
			r = SIG_BYTE1;
		end else if (a == `OPV_SIG_LOC2) begin
			r = SIG_BYTE2;
		end
		return r;
	endfunction

	opv_byte_t out_q;
	opv_byte_t out_d;
	logic      oe_q;
	logic      oe_d;

	// lock bits never reach port zero
	always_comb begin
		out_d = `OPV_IDLE_BYTE;
		oe_d  = 1'b0;
		if (mode == OPV_MODE_VERIFY && !lock2_q) begin
			out_d = ~(code_mem[code_addr] ^ enc_mem[enc_addr]);
			oe_d  = 1'b1;
		end else if (mode == OPV_MODE_SIGNATURE) begin
			out_d = sig_lookup(pin_addr);
			oe_d  = 1'b1;
		end
	end

	// drive only in read modes, enable low
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			out_q <= `OPV_IDLE_BYTE;
			oe_q  <= 1'b0;
		end else begin
			out_q <= out_d;
			oe_q  <= oe_d;
		end
	end

	// =================================================================
	// protection outputs; access level caught on the first edge after release
	logic caught_q;
	logic caught_d;
	logic ea_latch_q;
	logic ea_latch_d;
	logic [5:0] prot_q;
	logic [5:0] prot_d;

	always_comb begin
		caught_d   = 1'b1;
		ea_latch_d = caught_q ? ea_latch_q : ea_logic_high;
		// protection levels from the lock bits
		prot_d = {lock1_q, lock1_q && lock2_q, lock1_q && lock2_q && lock3_q,
		          lock1_q, lock1_q ? ea_latch_d : ea_logic_high,
		          lock1_q && lock2_q && lock3_q};
	end

	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			caught_q   <= 1'b0;
			ea_latch_q <= 1'b0;
			prot_q     <= 6'h00;
		end else begin
			caught_q   <= caught_d;
			ea_latch_q <= ea_latch_d;
			prot_q     <= prot_d;
		end
	end

	assign port0_out             = out_q;
	assign port0_oe              = oe_q;
	assign lock_level_one        = prot_q[5];
	assign lock_level_two        = prot_q[4];
	assign lock_level_three      = prot_q[3];
	assign code_table_read_block = prot_q[2];
	assign ea_effective          = prot_q[1];
	assign ext_exec_disable      = prot_q[0];

	// =================================================================
	// checks
	sequence s_pulse_low;
		strobe_q && !latch_or_program_strobe;
	endsequence

	sequence s_pulse_end;
		!strobe_q && latch_or_program_strobe;
	endsequence

	a_write_on_pulse: assert property (@(posedge clk) disable iff (!rst_sync_q)
		((s_pulse_low and (mode == OPV_MODE_PROG_CODE))
		 ##1 (s_pulse_end and (mode == OPV_MODE_PROG_CODE) and !lock1_q)) |-> code_we)
		else $error("strobe pulse did not commit");

	a_lock_blocks_write: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(lock1_q && write_en && mode == OPV_MODE_PROG_CODE)
		 |=> (code_mem[$past(code_addr)] == $past(code_mem[code_addr])))
		else $error("write accepted while locked");

	a_verify_xnor: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(mode == OPV_MODE_VERIFY && !lock2_q) |=> (oe_q && out_q ==
		 ~($past(code_mem[code_addr]) ^ $past(enc_mem[enc_addr]))))
		else $error("verify byte not encrypted code");

	a_verify_locked: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(mode == OPV_MODE_VERIFY && lock2_q) |=> !port0_oe)
		else $error("verify driven while disabled");

	a_enable_release: assert property (@(posedge clk) disable iff (!rst_sync_q)
		mode_sel_seven_enable |=> !port0_oe)
		else $error("port zero driven with enable high");

	a_sig_first: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(mode == OPV_MODE_SIGNATURE && pin_addr == `OPV_SIG_LOC0)
		 |=> (port0_oe && port0_out == SIG_BYTE0))
		else $error("wrong identification byte");

	a_prog_no_drive: assert property (@(posedge clk) disable iff (!rst_sync_q)
		vpp_present |=> !port0_oe)
		else $error("port zero driven while programming");

	a_exec_disable: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(lock1_q && lock2_q && lock3_q) ##1 1'b1 |-> ##1 ext_exec_disable)
		else $error("external execution not disabled");

endmodule

`default_nettype wire

// ===== shared/opv_defs.svh
// constants for the one-time-programmable program and verify port
`ifndef OPV_DEFS_SVH
`define OPV_DEFS_SVH

// =====================================================================
// array geometry
`define OPV_PIN_ADDR_W   13
`define OPV_ENC_IDX_W    6
`define OPV_ENC_DEPTH    64

// =====================================================================
// erased and idle values
`define OPV_ERASED_BYTE  8'hFF
`define OPV_IDLE_BYTE    8'hFF

// =====================================================================
// identification byte locations
`define OPV_SIG_LOC0     13'h0030
`define OPV_SIG_LOC1     13'h0031
`define OPV_SIG_LOC2     13'h0060

`endif

// ===== shared/opv_pkg.sv
// types shared by the program and verify port
package opv_pkg;

	// =================================================================
	// operating modes decoded from the select pins
	typedef enum logic [2:0] {
		OPV_MODE_IDLE,
		OPV_MODE_PROG_CODE,
		OPV_MODE_PROG_ENC,
		OPV_MODE_PROG_LOCK1,
		OPV_MODE_PROG_LOCK2,
		OPV_MODE_PROG_LOCK3,
		OPV_MODE_VERIFY,
		OPV_MODE_SIGNATURE
	} opv_mode_t;

	typedef logic [7:0] opv_byte_t;

endpackage

// ===== test/opv_prog_port_tb_top.sv
// self-checking bench for the program and verify port
`timescale 1ns/1ps
`default_nettype none

module opv_prog_port_tb_top;
	import opv_pkg::*;
	localparam logic [7:0] SIG0 = 8'hC3; // arbitrary value
	localparam logic [7:0] SIG1 = 8'h69; // arbitrary value
	localparam logic [7:0] SIG2 = 8'h1E; // arbitrary value
	logic clk;
	logic rst_n;
	wire logic rp, fs_n, stb, vpp, eah, s6, s7, s33, s36, s37, port0_oe;
	wire logic [7:0] addr_lo, port0_in, port0_out;
	wire logic [4:0] addr_hi;
	wire logic lk1, lk2, lk3, ctr_blk, ea_eff, ext_dis;
	int fail_count;
	int compares;
	logic [15:0] lfsr_q;
	opv_byte_t code_m [logic [12:0]];
	opv_byte_t enc_m [64];
	logic lock1, lock2;
	opv_byte_t rd, d;
	logic oe;
	logic [12:0] a;

	opv_prog_port #(.ADDR_W(13), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) i_dut (
		.clk, .rst_n, .reset_pin_high(rp), .program_fetch_strobe_n(fs_n),
		.latch_or_program_strobe(stb), .vpp_present(vpp), .ea_logic_high(eah),
		.mode_sel_six(s6), .mode_sel_seven_enable(s7), .mode_sel_three_three(s33),
		.mode_sel_three_six(s36), .mode_sel_three_seven(s37), .addr_lo, .addr_hi,
		.port0_in, .port0_out, .port0_oe, .lock_level_one(lk1), .lock_level_two(lk2),
		.lock_level_three(lk3), .code_table_read_block(ctr_blk), .ea_effective(ea_eff),
		.ext_exec_disable(ext_dis));

	opv_programmer_model i_prog (
		.clk, .reset_pin_high(rp), .program_fetch_strobe_n(fs_n),
		.latch_or_program_strobe(stb), .vpp_present(vpp), .ea_logic_high(eah),
		.mode_sel_six(s6), .mode_sel_seven_enable(s7), .mode_sel_three_three(s33),
		.mode_sel_three_six(s36), .mode_sel_three_seven(s37), .addr_lo, .addr_hi,
		.port0_in, .port0_out, .port0_oe);

	// =====================================================================
	// device clock kept running through the session
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [15:0] rnd(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic opv_byte_t exp_code(input logic [12:0] x);
		return code_m.exists(x) ? code_m[x] : 8'hFF;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic write_code(input logic [12:0] x, input opv_byte_t v);
		i_prog.prog_byte(5'b01111, x, v, 5);
		if (!lock1) begin
			code_m[x] = exp_code(x) & v;
		end
	endtask

	task automatic verify(input logic [12:0] x);
		i_prog.read(5'b00011, x, rd, oe);
		check(rd, lock2 ? 8'hFF : ~(exp_code(x) ^ enc_m[x[5:0]]));
		check({7'h0, oe}, {7'h0, !lock2});
	endtask

	task automatic do_reset();
		rst_n = 1'b0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask

	task automatic results();
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#80000;
		fail_count++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		fail_count = 0;
		compares = 0;
		lfsr_q = 16'h001D;
		lock1 = 1'b0;
		lock2 = 1'b0;
		foreach (enc_m[i]) enc_m[i] = 8'hFF;
		do_reset();
		check({lk1, lk2, lk3, ctr_blk, ext_dis}, 8'h00);
		i_prog.access_level(1'b0);
		repeat (2) @(negedge clk);
		check({7'h0, ea_eff}, 8'h00);
		i_prog.access_level(1'b1);
		verify(13'h0000);
		// address and data changed byte after byte
		for (int i = 0; i < 8; i++) begin
			lfsr_q = rnd(lfsr_q);
			a = lfsr_q[12:0];
			lfsr_q = rnd(lfsr_q);
			write_code(a, lfsr_q[7:0]);
			verify(a);
		end
		write_code(13'h1FFF, 8'h0F);
		write_code(13'h1FFF, 8'hF0);
		verify(13'h1FFF);
		lfsr_q = rnd(lfsr_q);
		a = {7'h00, lfsr_q[5:0]};
		d = lfsr_q[15:8];
		i_prog.prog_byte(5'b01101, a, d, 25);
		enc_m[a[5:0]] = enc_m[a[5:0]] & d;
		verify(a);
		verify(a | 13'h0440);
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 13'h030 : (i == 1) ? 13'h031 : (i == 2) ? 13'h060 : 13'h061;
			d = (i == 0) ? SIG0 : (i == 1) ? SIG1 : (i == 2) ? SIG2 : 8'hFF;
			i_prog.read(5'b00000, a, rd, oe);
			check(rd, d);
		end
		i_prog.release_bus();
		check(port0_in, 8'hFF);
		check({7'h0, port0_oe}, 8'h00);
		i_prog.prog_byte(5'b11111, 13'h0000, 8'hFF, 25);
		lock1 = 1'b1;
		repeat (2) @(negedge clk);
		check({6'h0, lk1, ctr_blk}, 8'h03);
		i_prog.read(5'b11111, 13'h0000, rd, oe);
		check({7'h0, oe}, 8'h00);
		write_code(13'h0005, 8'h00);
		verify(13'h0005);
		i_prog.prog_byte(5'b11100, 13'h0000, 8'hFF, 25);
		lock2 = 1'b1;
		verify(13'h1FFF);
		i_prog.read(5'b00000, 13'h031, rd, oe);
		check(rd, SIG1);
		i_prog.prog_byte(5'b10110, 13'h0000, 8'hFF, 25);
		repeat (2) @(negedge clk);
		check({7'h0, ext_dis}, 8'h01);
		do_reset();
		i_prog.access_level(1'b0);
		repeat (2) @(negedge clk);
		check({5'h0, ea_eff, lk3, lk2}, 8'h07);
		results();
	end
endmodule

`default_nettype wire

// ===== test/opv_programmer_model.sv
// programmer model driving the program and verify pins of the port
`timescale 1ns/1ps
`default_nettype none

module opv_programmer_model (
	input  wire logic       clk,                     // device oscillator
	output logic            reset_pin_high,          // reset at program level
	output logic            program_fetch_strobe_n,  // held low in all modes
	output logic            latch_or_program_strobe, // write pulse, low active
	output logic            vpp_present,             // programming voltage on
	output logic            ea_logic_high,           // access pin at logic high
	output logic            mode_sel_six,            // select pin
	output logic            mode_sel_seven_enable,   // select and read enable
	output logic            mode_sel_three_three,    // select pin
	output logic            mode_sel_three_six,      // select pin
	output logic            mode_sel_three_seven,    // select pin
	output logic [7:0]      addr_lo,                 // low address port
	output logic [4:0]      addr_hi,                 // upper address bits
	output wire logic [7:0] port0_in,                // wired port zero level
	input  wire logic [7:0] port0_out,               // device drive value
	input  wire logic       port0_oe                 // device drives port zero
);
	logic [7:0] drive_q; // byte put on port zero
	logic       hold_q;  // programmer pulls port zero
	// =====================================================================
	// open drain with pull-ups: a released pin reads high, parties only pull low
	// write byte presented on port zero
	assign port0_in = (port0_oe ? port0_out : 8'hFF) & (hold_q ? drive_q : 8'hFF);

	// fixed reset and fetch strobe levels
	initial begin
		reset_pin_high = 1'b1;
		program_fetch_strobe_n = 1'b0;
		latch_or_program_strobe = 1'b1;
		vpp_present = 1'b0;
		ea_logic_high = 1'b1;
		{addr_hi, addr_lo} = 13'h0000;
		drive_q = 8'hFF;
		hold_q = 1'b0;
		set_mode(5'b10000);
	end

	task automatic set_mode(input logic [4:0] sel);
		{mode_sel_six, mode_sel_seven_enable, mode_sel_three_three,
			mode_sel_three_six, mode_sel_three_seven} = sel;
	endtask

	// address, data, mode, voltage, then pulses
	task automatic prog_byte(input logic [4:0] sel, input logic [12:0] addr,
			input logic [7:0] data, input int pulses);
		@(negedge clk);
		// low byte and five upper bits
		{addr_hi, addr_lo} = addr;
		drive_q = data;
		hold_q = 1'b1;
		set_mode(sel);
		@(negedge clk);
		// voltage raised only around the pulses
		ea_logic_high = 1'b0;
		vpp_present = 1'b1;
		@(negedge clk);
		// one low cycle per pulse, stable pins
		repeat (pulses) begin
			latch_or_program_strobe = 1'b0;
			@(negedge clk);
			latch_or_program_strobe = 1'b1;
			@(negedge clk);
		end
		// back at logic high before any verify
		vpp_present = 1'b0;
		ea_logic_high = 1'b1;
		hold_q = 1'b0;
		set_mode(5'b10000);
	endtask

	task automatic read(input logic [4:0] sel, input logic [12:0] addr,
			output logic [7:0] data, output logic oe);
		@(negedge clk);
		{addr_hi, addr_lo} = addr;
		set_mode(sel);
		repeat (2) @(negedge clk);
		data = port0_in;
		oe = port0_oe;
	endtask

	task automatic access_level(input logic v);
		@(negedge clk);
		ea_logic_high = v;
	endtask

	task automatic release_bus();
		@(negedge clk);
		mode_sel_seven_enable = 1'b1;
		repeat (2) @(negedge clk);
	endtask
endmodule

`default_nettype wire
